// File: design/fps_controller.sv
// Host controller that programs an asynchronous flash over its pins
`timescale 1ns/1ns
`default_nettype none
`include "fps_defs.svh"
module fps_controller #(
	parameter int ADDR_W = 22,
	parameter int WORDS  = `FPS_ACCEL_WORDS,
	parameter int RST_CYC = `FPS_BUS_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   chip_select_n,
	output logic                   output_enable_n,
	output logic                   write_enable_n,
	output logic                   flash_reset_n,
	input  wire logic [15:0]       data_lines_in,
	output logic [15:0]            data_lines_out,
	output logic                   data_lines_oe_n
);
	logic [ADDR_W-1:0] addr_reg;
	logic [15:0]       data_reg;
	logic [15:0]       cmd_reg;
	logic [5:0]        len_reg;
	logic [15:0]       buf_mem [WORDS];
	logic [4:0]        buf_wptr;
	logic [5:0]        idx;
	logic [15:0]       fstat;
	logic [15:0]       rd_word;
	logic              busy;
	logic              err;
	logic              reset_req;
	fps_pkg::fps_op_t  op;
	fps_pkg::fps_state_t state;
	logic              go;
	logic              cyc_start;
	logic              cyc_wr;
	logic [15:0]       cyc_data;
	logic              cyc_busy;
	logic              cyc_done;
	logic [15:0]       cyc_rdata;
	logic [7:0]        rst_cnt;
	logic              second;
	logic              aw_ok;
	logic              w_ok;
	logic [7:0]        aw_addr;
	logic [31:0]       w_data;

	function automatic logic [15:0] op_code(input fps_pkg::fps_op_t o);
		case (o)
			fps_pkg::FPS_OP_PROGRAM: op_code = `FPS_CMD_PROGRAM;
			fps_pkg::FPS_OP_SUSPEND: op_code = `FPS_CMD_SUSPEND;
			fps_pkg::FPS_OP_RESUME:  op_code = `FPS_CMD_CONFIRM;
			fps_pkg::FPS_OP_ACCEL:   op_code = `FPS_CMD_ACCEL;
			fps_pkg::FPS_OP_STATUS:  op_code = `FPS_CMD_READ_STAT;
			default:                 op_code = `FPS_CMD_READ_ARRAY;
		endcase
	endfunction

	// AXI4-Lite write path: address and data latched in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				w_data <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (aw_ok && w_ok && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr > `FPS_REG_WRDATA) ? 2'b10 : 2'b00;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;

	// Register writes; strobes ignored since every field is one word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg <= '0;
			data_reg <= 16'h0000;
			cmd_reg <= 16'h0000;
			len_reg <= 6'd32;
			buf_wptr <= 5'd0;
			op <= fps_pkg::FPS_OP_NONE;
			reset_req <= 1'b0;
			go <= 1'b0;
		end else begin
			go <= 1'b0;
			if (wr_fire && !busy) begin
				case (aw_addr)
					`FPS_REG_CTRL: begin
						op <= fps_pkg::fps_op_t'(w_data[`FPS_CTRL_OP_LSB +: `FPS_CTRL_OP_W]);
						reset_req <= w_data[`FPS_CTRL_RESET_BIT];
						go <= 1'b1;
					end
					`FPS_REG_ADDR: addr_reg <= w_data[ADDR_W-1:0];
					`FPS_REG_DATA: begin
						data_reg <= w_data[15:0];
						cmd_reg <= w_data[31:16];
					end
					`FPS_REG_LEN: begin
						len_reg <= w_data[5:0];
						buf_wptr <= 5'd0;
					end
					`FPS_REG_WRDATA: buf_wptr <= buf_wptr + 5'd1;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (wr_fire && !busy && aw_addr == `FPS_REG_WRDATA) begin
			buf_mem[buf_wptr] <= w_data[15:0];
		end
	end

	// Sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fps_pkg::FPS_IDLE;
			busy <= 1'b0;
			err <= 1'b0;
			cyc_start <= 1'b0;
			cyc_wr <= 1'b0;
			cyc_data <= 16'h0000;
			flash_addr <= '0;
			flash_reset_n <= 1'b0;
			rst_cnt <= 8'h00;
			idx <= 6'd0;
			second <= 1'b0;
			fstat <= 16'h0000;
			rd_word <= 16'h0000;
		end else begin
			cyc_start <= 1'b0;
			case (state)
				fps_pkg::FPS_IDLE: begin
					flash_reset_n <= 1'b1;
					if (go) begin
						busy <= 1'b1;
						err <= 1'b0;
						second <= 1'b0;
						idx <= 6'd0;
						if (reset_req) begin
							flash_reset_n <= 1'b0;
							rst_cnt <= 8'(RST_CYC);
							state <= fps_pkg::FPS_RST;
						end else if (op == fps_pkg::FPS_OP_ACCEL && addr_reg[4:0] != 5'd0) begin
							err <= 1'b1;
							state <= fps_pkg::FPS_DONE;
						end else begin
							flash_addr <= addr_reg;
							cyc_wr <= 1'b1;
							cyc_data <= (op == fps_pkg::FPS_OP_COMMAND) ? cmd_reg : op_code(op);
							cyc_start <= 1'b1;
							state <= fps_pkg::FPS_WRITE;
						end
					end
				end
				fps_pkg::FPS_WRITE: begin
					if (cyc_done) begin
						state <= fps_pkg::FPS_NEXT;
					end
				end
				fps_pkg::FPS_NEXT: begin
					if (op == fps_pkg::FPS_OP_PROGRAM && !second) begin
						second <= 1'b1;
						cyc_data <= data_reg;
						cyc_start <= 1'b1;
						state <= fps_pkg::FPS_WRITE;
					end else if (op == fps_pkg::FPS_OP_ACCEL && idx != 6'(WORDS)) begin
						// Same start address, no polling, pad past length
						cyc_data <= (idx < len_reg) ? buf_mem[idx[4:0]] : `FPS_PAD_WORD;
						idx <= idx + 6'd1;
						cyc_start <= 1'b1;
						state <= fps_pkg::FPS_WRITE;
					end else if (op == fps_pkg::FPS_OP_READ || op == fps_pkg::FPS_OP_STATUS
							|| op == fps_pkg::FPS_OP_PROGRAM || op == fps_pkg::FPS_OP_ACCEL
							|| op == fps_pkg::FPS_OP_SUSPEND) begin
						cyc_wr <= 1'b0;
						cyc_start <= 1'b1;
						state <= fps_pkg::FPS_READ;
					end else begin
						state <= fps_pkg::FPS_DONE;
					end
				end
				fps_pkg::FPS_READ: begin
					if (cyc_done) begin
						if (op == fps_pkg::FPS_OP_READ) begin
							rd_word <= cyc_rdata;
							state <= fps_pkg::FPS_DONE;
						end else begin
							fstat <= cyc_rdata;
							// Poll until ready; suspend also sets the suspended bit
							if (cyc_rdata[`FPS_SR_READY_BIT]) begin
								state <= fps_pkg::FPS_DONE;
							end else begin
								cyc_start <= 1'b1;
							end
						end
					end
				end
				fps_pkg::FPS_RST: begin
					if (rst_cnt != 8'h00) begin
						rst_cnt <= rst_cnt - 8'h01;
					end else begin
						flash_reset_n <= 1'b1;
						state <= fps_pkg::FPS_DONE;
					end
				end
				fps_pkg::FPS_DONE: begin
					busy <= 1'b0;
					state <= fps_pkg::FPS_IDLE;
				end
				default: state <= fps_pkg::FPS_IDLE;
			endcase
		end
	end

	fps_bus_cycle #(
		.CYC(`FPS_BUS_CYC)
	) i_fps_bus_cycle (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.start          (cyc_start),
		.is_write       (cyc_wr),
		.wdata          (cyc_data),
		.data_lines_in  (data_lines_in),
		.busy           (cyc_busy),
		.done           (cyc_done),
		.rdata          (cyc_rdata),
		.chip_select_n  (chip_select_n),
		.output_enable_n(output_enable_n),
		.write_enable_n (write_enable_n),
		.data_lines_out (data_lines_out),
		.data_lines_oe_n(data_lines_oe_n)
	);

	// AXI4-Lite read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`FPS_REG_CTRL: s_axi_rdata <= {27'h0, reset_req, 1'b0, op};
					`FPS_REG_ADDR: s_axi_rdata <= 32'(addr_reg);
					`FPS_REG_DATA: s_axi_rdata <= {cmd_reg, data_reg};
					`FPS_REG_STATUS: s_axi_rdata <= {29'h0, cyc_busy, err, busy};
					`FPS_REG_FLASHSTAT: s_axi_rdata <= {16'h0000, fstat};
					`FPS_REG_READDATA: s_axi_rdata <= {16'h0000, rd_word};
					`FPS_REG_LEN: s_axi_rdata <= {21'h0, buf_wptr, len_reg};
					`FPS_REG_WRDATA: s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: include/fps_defs.svh
// Offsets, field positions, command codes and timing counts for the flash program controller
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

`define FPS_REG_CTRL       8'h00
`define FPS_REG_ADDR       8'h04
`define FPS_REG_DATA       8'h08
`define FPS_REG_STATUS     8'h0C
`define FPS_REG_FLASHSTAT  8'h10
`define FPS_REG_READDATA   8'h14
`define FPS_REG_LEN        8'h18
`define FPS_REG_WRDATA     8'h1C

`define FPS_CTRL_OP_LSB    0
`define FPS_CTRL_OP_W      3
`define FPS_CTRL_RESET_BIT 4

`define FPS_CMD_PROGRAM    16'h0040
`define FPS_CMD_ACCEL      16'h0010
`define FPS_CMD_SUSPEND    16'h00B0
`define FPS_CMD_CONFIRM    16'h00D0
`define FPS_CMD_READ_ARRAY 16'h00FF
`define FPS_CMD_READ_STAT  16'h0070
`define FPS_PAD_WORD       16'hFFFF

`define FPS_SR_READY_BIT   7
`define FPS_SR_PSUSP_BIT   2

`define FPS_ACCEL_WORDS    32
`define FPS_BUS_NS         100
`define FPS_CLK_NS         20
`define FPS_BUS_CYC        ((`FPS_BUS_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)

`endif

// File: include/fps_pkg.sv
// Types for the flash program controller
package fps_pkg;
	typedef enum logic [2:0] {
		FPS_OP_NONE    = 3'd0,
		FPS_OP_PROGRAM = 3'd1,
		FPS_OP_SUSPEND = 3'd2,
		FPS_OP_RESUME  = 3'd3,
		FPS_OP_ACCEL   = 3'd4,
		FPS_OP_READ    = 3'd5,
		FPS_OP_STATUS  = 3'd6,
		FPS_OP_COMMAND = 3'd7
	} fps_op_t;
	typedef enum logic [6:0] {
		FPS_IDLE  = 7'b000_0001,
		FPS_WRITE = 7'b000_0010,
		FPS_READ  = 7'b000_0100,
		FPS_NEXT  = 7'b000_1000,
		FPS_POLL  = 7'b001_0000,
		FPS_RST   = 7'b010_0000,
		FPS_DONE  = 7'b100_0000
	} fps_state_t;
endpackage

// File: design/fps_bus_cycle.sv
// One timed write or read cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "fps_defs.svh"
module fps_bus_cycle #(
	parameter int CYC = `FPS_BUS_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] data_lines_in,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             chip_select_n,
	output logic             output_enable_n,
	output logic             write_enable_n,
	output logic [15:0]      data_lines_out,
	output logic             data_lines_oe_n
);
	logic [7:0] cnt;
	logic       wr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 8'h00;
			wr <= 1'b0;
			rdata <= 16'h0000;
			chip_select_n <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			data_lines_out <= 16'h0000;
			data_lines_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				wr <= is_write;
				cnt <= 8'(CYC);
				chip_select_n <= 1'b0;
				// Write cycle: select low, output enable high, write enable low
				output_enable_n <= is_write;
				write_enable_n <= !is_write;
				data_lines_out <= wdata;
				data_lines_oe_n <= !is_write;
			end else if (busy) begin
				if (cnt != 8'h00) begin
					cnt <= cnt - 8'h01;
				end else begin
					// Data sampled before strobes rise so hold time is met
					if (!wr) begin
						rdata <= data_lines_in;
					end
					busy <= 1'b0;
					done <= 1'b1;
					chip_select_n <= 1'b1;
					output_enable_n <= 1'b1;
					write_enable_n <= 1'b1;
					data_lines_oe_n <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/fps_controller_assertions.sv
// Pin and register bus checks for the flash program controller
`timescale 1ns/1ns
`default_nettype none
module fps_controller_assertions #(
	parameter int ADDR_W = 22
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              chip_select_n,
	input wire logic              output_enable_n,
	input wire logic              write_enable_n,
	input wire logic              flash_reset_n,
	input wire logic [15:0]       data_lines_out,
	input wire logic              data_lines_oe_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_reset_release: assert property ($rose(aresetn) |-> (!flash_reset_n && chip_select_n
		&& data_lines_oe_n && !s_axi_bvalid && !s_axi_rvalid) ##[1:2] flash_reset_n)
		else $error("pins wrong around reset release");
	a_write_cycle: assert property (!write_enable_n |-> (!chip_select_n && output_enable_n
		&& flash_reset_n && !data_lines_oe_n)) else $error("bad write cycle levels");
	a_read_cycle: assert property (!output_enable_n |-> (!chip_select_n && write_enable_n
		&& flash_reset_n && data_lines_oe_n)) else $error("bad read cycle levels");
	a_float_idle: assert property ((chip_select_n || !flash_reset_n) |-> data_lines_oe_n)
		else $error("data driven while deselected");
	a_strobe_width: assert property ($fell(write_enable_n) |-> !write_enable_n [*6]
		##1 write_enable_n) else $error("write strobe width wrong");
	a_write_stable: assert property (!write_enable_n && !$past(write_enable_n)
		|-> $stable(data_lines_out) && $stable(flash_addr)) else $error("write data moved");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response dropped");
	// Both halves are latched on the first edge, the response is raised on the next one
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	c_write: cover property ($fell(write_enable_n));
	c_read: cover property ($fell(output_enable_n));
	c_flash_reset: cover property ($fell(flash_reset_n));
endmodule
bind fps_controller fps_controller_assertions #(.ADDR_W(ADDR_W)) i_fps_controller_assertions (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .flash_addr, .chip_select_n, .output_enable_n,
	.write_enable_n, .flash_reset_n, .data_lines_out, .data_lines_oe_n);
`default_nettype wire

// File: bench/fps_flash_model.sv
// Behavioural flash bank: command decoder, program, suspend and buffered program
`timescale 1ns/1ns
`default_nettype none
module fps_flash_model #(
	parameter int ADDR_W   = 22,
	parameter int PROG_CYC = 300
) (
	input  wire logic              aclk,
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic              chip_select_n,
	input  wire logic              output_enable_n,
	input  wire logic              write_enable_n,
	input  wire logic              flash_reset_n,
	input  wire logic [15:0]       data_lines_out,
	input  wire logic              data_lines_oe_n,
	output logic [15:0]            data_lines_in
);
	logic [15:0]       mem [logic [ADDR_W-1:0]];
	logic [15:0]       buf_w [32];
	logic [ADDR_W-1:0] pend_addr, cap_a;
	logic [15:0]       pend_data, cap_d, last_out = 16'h0000;
	logic              we_q = 1'b1, cs_q = 1'b1, setup = 1'b0, susp = 1'b0;
	logic              show_status = 1'b0, acc_run = 1'b0;
	int                busy = 0, acc_cnt = -1, host_faults = 0;
	wire               reading = flash_reset_n && !chip_select_n && !output_enable_n && write_enable_n;
	wire  [15:0]       status = {8'h00, busy == 0 || susp, 4'h0, susp, 2'h0};
	// Released lines show the inverse of the last value, so a stale sample never matches
	always @* begin
		if (reading)
			data_lines_in = show_status ? status : (mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF);
		else
			data_lines_in = ~last_out;
	end
	// Acts mid-cycle so the controller samples settled data at the rising edge
	always @(negedge aclk) begin
		if (!flash_reset_n) begin
			busy = 0;
			susp = 1'b0;
			setup = 1'b0;
			acc_cnt = -1;
			show_status = 1'b0;
		end else begin
			if (reading)
				last_out = data_lines_in;
			if (reading && acc_cnt >= 0) host_faults++;
			if (reading && susp && !show_status && flash_addr == pend_addr) host_faults++;
			if (busy > 0 && !susp) begin
				busy--;
				if (busy == 0 && acc_run) for (int i = 0; i < 32; i++) mem[pend_addr + i] = buf_w[i];
				else if (busy == 0) mem[pend_addr] = pend_data;
				if (busy == 0) acc_run = 1'b0;
			end
			if (write_enable_n && !we_q && !cs_q) begin
				if (acc_cnt >= 0) begin
					if (cap_a != pend_addr) host_faults++;
					buf_w[acc_cnt] = cap_d;
					acc_cnt++;
					if (acc_cnt == 32) begin
						acc_cnt = -1;
						acc_run = 1'b1;
						busy = PROG_CYC;
						show_status = 1'b1;
					end
				end else if (setup) begin
					setup = 1'b0;
					pend_addr = cap_a;
					pend_data = cap_d;
					busy = PROG_CYC;
					show_status = 1'b1;
				end else if (busy > 0 && !susp) begin
					if (cap_d[7:0] == 8'hB0) susp = 1'b1;
				end else if (susp) begin
					case (cap_d[7:0])
						8'hFF: show_status = 1'b0;
						8'h70, 8'h90, 8'h98: show_status = 1'b1;
						8'hD0: begin
							susp = 1'b0;
							show_status = 1'b1;
						end
						default: ;
					endcase
				end else case (cap_d[7:0])
					8'hFF: show_status = 1'b0;
					8'h40: setup = 1'b1;
					8'h10: begin
						acc_cnt = 0;
						pend_addr = cap_a;
						if (cap_a[4:0] != 5'h00) host_faults++;
					end
					default: show_status = 1'b1;
				endcase
			end
		end
		we_q = write_enable_n;
		cs_q = chip_select_n;
		cap_d = data_lines_out;
		cap_a = flash_addr;
	end
endmodule
`default_nettype wire

// File: bench/fps_controller_bench.sv
// Register-level tests of the flash program controller against the flash model
`timescale 1ns/1ns
`default_nettype none
`include "fps_defs.svh"
module fps_controller_bench;
	logic        aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, data_lines_oe_n;
	logic        chip_select_n, output_enable_n, write_enable_n, flash_reset_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rres, bres;
	logic [21:0] flash_addr;
	logic [15:0] data_lines_in, data_lines_out;
	int          fail_count = 0, n_tests = 0, cycles = 0;
	fps_controller i_fps_controller (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.flash_addr, .chip_select_n, .output_enable_n, .write_enable_n, .flash_reset_n,
		.data_lines_in, .data_lines_out, .data_lines_oe_n);
	fps_flash_model #(.PROG_CYC(300)) i_fps_flash_model (.aclk, .flash_addr, .chip_select_n,
		.output_enable_n, .write_enable_n, .flash_reset_n, .data_lines_out,
		.data_lines_oe_n, .data_lines_in);
	always #10 aclk = ~aclk;
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Ceiling sits well above the few thousand cycles the sequence needs
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw_ok) s_axi_awvalid <= 1'b0;
			if (s_axi_awready) aw_ok = 1'b1;
			if (s_axi_wready && !w_ok) s_axi_wvalid <= 1'b0;
			if (s_axi_wready) w_ok = 1'b1;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		bres = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rres = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic run(input logic [31:0] ctrl);
		wr(`FPS_REG_CTRL, ctrl);
		do rd(`FPS_REG_STATUS); while (rdat[0] !== 1'b0);
	endtask
	task automatic read_word(input logic [31:0] a, input logic [31:0] exp, input string msg);
		wr(`FPS_REG_ADDR, a);
		run(32'h0000_0005);
		rd(`FPS_REG_READDATA);
		check(rdat & 32'h0000_FFFF, exp, msg);
	endtask
	task automatic raw_program(input logic [31:0] a, input logic [31:0] word_hi);
		wr(`FPS_REG_ADDR, a);
		wr(`FPS_REG_DATA, 32'h0040_0000);
		run(32'h0000_0007);
		wr(`FPS_REG_DATA, word_hi);
		run(32'h0000_0007);
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`FPS_REG_LEN);
		check(rdat & 32'h0000_07FF, 32'h0000_0020, "length reset value");
		rd(8'h20);
		check(32'(rres), 32'h0000_0002, "unmapped read response");
		wr(8'h20, 32'h0000_0000);
		check(32'(bres), 32'h0000_0002, "unmapped write response");
		wr(`FPS_REG_ADDR, 32'h0000_0100);
		check(32'(bres), 32'h0000_0000, "mapped write response");
		wr(`FPS_REG_DATA, 32'h0000_1234);
		run(32'h0000_0001);
		rd(`FPS_REG_FLASHSTAT);
		check(rdat & 32'h0000_0080, 32'h0000_0080, "ready after program");
		read_word(32'h0000_0100, 32'h0000_1234, "program readback");
		wr(`FPS_REG_ADDR, 32'h0000_0040);
		wr(`FPS_REG_LEN, 32'h0000_0003);
		for (int i = 0; i < 3; i++) wr(`FPS_REG_WRDATA, 32'h0000_A000 + 32'(i));
		run(32'h0000_0004);
		for (int i = 0; i < 32; i++) check({16'h0000, i_fps_flash_model.buf_w[i]},
			(i < 3) ? 32'h0000_A000 + 32'(i) : 32'h0000_FFFF, "buffer word");
		read_word(32'h0000_0042, 32'h0000_A002, "buffered readback");
		raw_program(32'h0000_0200, 32'h5A5A_0000);
		run(32'h0000_0002);
		rd(`FPS_REG_FLASHSTAT);
		check(rdat & 32'h0000_0084, 32'h0000_0084, "suspended status");
		read_word(32'h0000_0100, 32'h0000_1234, "read while suspended");
		run(32'h0000_0003);
		wr(`FPS_REG_ADDR, 32'h0000_0200);
		do begin
			run(32'h0000_0006);
			rd(`FPS_REG_FLASHSTAT);
		end while (rdat[7] !== 1'b1);
		check(rdat & 32'h0000_0084, 32'h0000_0080, "resumed to completion");
		read_word(32'h0000_0200, 32'h0000_5A5A, "resumed word");
		raw_program(32'h0000_0300, 32'h7777_0000);
		run(32'h0000_0010);
		repeat (400) @(posedge aclk);
		check(32'(i_fps_flash_model.mem.exists(22'h00_0300)), 32'h0000_0000, "abort");
		wr(`FPS_REG_ADDR, 32'h0000_0045);
		wr(`FPS_REG_CTRL, 32'h0000_0004);
		rd(`FPS_REG_STATUS);
		check(rdat & 32'h0000_0003, 32'h0000_0002, "unaligned refused");
		check(32'(i_fps_flash_model.host_faults), 32'h0000_0000, "host faults");
		test_done();
	end
endmodule
`default_nettype wire
